// ==== sdc_pkg.sv ====
// Purpose: Shared constants and types for the chain shifter
// Assumes: Serial link sampled by the 100 MHz core clock
// Notes:   Command field sits in the top four bits of the word
package sdc_pkg;
  localparam int          SDC_WORD_W      = 24;
  localparam int          SDC_CMD_MSB     = 23;
  localparam int          SDC_CMD_LSB     = 20;
  localparam logic [3:0]  SDC_CMD_CHAIN   = 4'h8;
  localparam int          SDC_CHAIN_BIT   = 0;
  localparam logic        SDC_CHAIN_RST   = 1'b0;
  localparam logic [23:0] SDC_WORD_RST    = 24'h000000;
  localparam int          SDC_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    SDC_IDLE  = 2'b00,
    SDC_SHIFT = 2'b01,
    SDC_LATCH = 2'b11
  } sdc_state_e;
endpackage

// ==== sdc_if.sv ====
// Purpose: Carries synchronised link events from sampler to shifter
// Assumes: All signals on i_clk
// Notes:   Edges are one-cycle pulses
`timescale 1ns/100ps
interface sdc_if;
  logic sclk_rise;
  logic sclk_fall;
  logic sync_fall;
  logic sync_rise;
  logic sync_low;
  logic data_in;
  modport src (output sclk_rise, output sclk_fall, output sync_fall, output sync_rise,
               output sync_low, output data_in);
  modport dst (input sclk_rise, input sclk_fall, input sync_fall, input sync_rise,
               input sync_low, input data_in);
endinterface

// ==== sdc_sampler.sv ====
// Purpose: Three-flop sampling of link pins and edge detection
// Assumes: Pins asynchronous to i_clk
// Notes:   A change counts once stages two and three agree
`timescale 1ns/100ps
module sdc_sampler
  import sdc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_sclk,
  input  wire logic i_sync_n,
  input  wire logic i_serial_data_in,
  sdc_if.src        bus
);
  logic [SDC_SYNC_STAGES-1:0] sclk_sr;
  logic [SDC_SYNC_STAGES-1:0] sync_sr;
  logic [SDC_SYNC_STAGES-1:0] data_sr;
  logic [SDC_SYNC_STAGES-1:0] next_sclk_sr;
  logic [SDC_SYNC_STAGES-1:0] next_sync_sr;
  logic [SDC_SYNC_STAGES-1:0] next_data_sr;
  logic                       sclk_q;
  logic                       sync_q;
  logic                       data_q;
  logic                       next_sclk_q;
  logic                       next_sync_q;
  logic                       next_data_q;

  always_comb begin
    next_sclk_sr = {sclk_sr[SDC_SYNC_STAGES-2:0], i_sclk};
    next_sync_sr = {sync_sr[SDC_SYNC_STAGES-2:0], i_sync_n};
    next_data_sr = {data_sr[SDC_SYNC_STAGES-2:0], i_serial_data_in};
    next_sclk_q  = (sclk_sr[1] == sclk_sr[2]) ? sclk_sr[2] : sclk_q;
    next_sync_q  = (sync_sr[1] == sync_sr[2]) ? sync_sr[2] : sync_q;
    next_data_q  = (data_sr[1] == data_sr[2]) ? data_sr[2] : data_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_sr <= '0;
      sync_sr <= '1;
      data_sr <= '0;
      sclk_q  <= 1'b0;
      sync_q  <= 1'b1;
      data_q  <= 1'b0;
    end else begin
      sclk_sr <= next_sclk_sr;
      sync_sr <= next_sync_sr;
      data_sr <= next_data_sr;
      sclk_q  <= next_sclk_q;
      sync_q  <= next_sync_q;
      data_q  <= next_data_q;
    end
  end

  assign bus.sclk_rise = next_sclk_q & ~sclk_q;
  assign bus.sclk_fall = ~next_sclk_q & sclk_q;
  assign bus.sync_fall = ~next_sync_q & sync_q;
  assign bus.sync_rise = next_sync_q & ~sync_q;
  assign bus.sync_low  = ~sync_q;
  assign bus.data_in   = data_q;
endmodule // sdc_sampler

// ==== sdc_chain_shifter.sv ====
// Purpose: 24-bit input shift register with daisy-chain output
// Assumes: Host keeps frame counts; link pins sampled by i_clk
// Notes:   Latched word feeds the command logic outside
// Operation
// RULE1 - While frame sync is low each serial clock shifts serial_data_in into the register.
// RULE2 - Bits pushed past the 24th position leave in order on serial_data_out.
// RULE3 - serial_data_out changes on the rising clock and is stable at the next falling edge.
// RULE4 - The system links each serial_data_out to the next device input, sharing clock and sync.
// RULE5 - The host sends 24 clocks per chained device in each frame.
// RULE6 - A frame ending off a multiple of 24 clocks is still latched as valid.
// RULE7 - Sync rising latches the register and further clocks are ignored until sync falls.
// RULE8 - With a free clock the host holds sync low for exactly the needed cycles.
// RULE9 - With a gated clock the host bursts the exact count and raises sync after it.
// RULE10 - With chain_enable set the device runs in chain mode with serial_data_out active.
// RULE11 - Command 1000 writes chain_enable from data_bit_zero of the word.
// RULE12 - After reset the device is standalone with chain_enable cleared.
// RULE13 - The register shifts MSB first so the earliest bit leaves first.
`timescale 1ns/100ps
module sdc_chain_shifter
  import sdc_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_sclk,
  input  wire logic                  i_sync_n,
  input  wire logic                  i_serial_data_in,
  output logic                       o_serial_data_out,
  output logic                       o_serial_data_out_oe,
  output logic                       o_chain_enable,
  output logic [SDC_WORD_W-1:0]      o_word,
  output logic                       o_word_valid
);
  sdc_if lnk ();

  // Pin sampling and edge pulses
  sdc_sampler u_sampler (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_sclk           (i_sclk),
    .i_sync_n         (i_sync_n),
    .i_serial_data_in (i_serial_data_in),
    .bus              (lnk)
  );

  // Frame state and shift path
  sdc_state_e            state;
  sdc_state_e            next_state;
  logic [SDC_WORD_W-1:0] shreg;
  logic [SDC_WORD_W-1:0] next_shreg;
  logic                  dout;
  logic                  next_dout;
  // Hand-over, mode and pin
  logic [SDC_WORD_W-1:0] word;
  logic [SDC_WORD_W-1:0] next_word;
  logic                  word_valid;
  logic                  next_word_valid;
  logic                  chain_en;
  logic                  next_chain_en;
  logic                  dout_pin;
  logic                  next_dout_pin;
  logic                  dout_oe;
  logic                  next_dout_oe;
  logic                  data_bit_zero;
  logic                  close_edge;
  logic                  shift_edge;
  logic                  out_edge;

  // Command field decode
  function automatic logic is_chain_cmd(input logic [SDC_WORD_W-1:0] w);
    return w[SDC_CMD_MSB:SDC_CMD_LSB] == SDC_CMD_CHAIN;
  endfunction

  // Link edges count only while a frame is open
  function automatic logic frame_open(input sdc_state_e s);
    return s == SDC_SHIFT;
  endfunction

  assign data_bit_zero = shreg[SDC_CHAIN_BIT];
  assign close_edge    = frame_open(state) & lnk.sync_rise;
  assign shift_edge    = frame_open(state) & ~lnk.sync_rise & lnk.sclk_fall;
  assign out_edge      = frame_open(state) & ~lnk.sync_rise & lnk.sclk_rise;

  // Frame state
  always_comb begin
    next_state = state;
    case (state)
      SDC_IDLE: begin
        if (lnk.sync_fall) begin
          next_state = SDC_SHIFT;
        end
      end
      SDC_SHIFT: begin
        if (close_edge) begin
          next_state = SDC_LATCH;                                  // see RULE7
        end
      end
      SDC_LATCH: begin
        next_state = SDC_IDLE;                                     // see RULE7
      end
      default: begin
        next_state = SDC_IDLE;
      end
    endcase
  end

  // Frame state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SDC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Shift on falling link clock, show the top bit on rising
  always_comb begin
    next_shreg = shreg;
    next_dout  = dout;
    case (state)
      SDC_SHIFT: begin
        if (shift_edge) begin
          next_shreg = {shreg[SDC_WORD_W-2:0], lnk.data_in};      // see RULE1 see RULE13
        end
        if (out_edge) begin
          next_dout = shreg[SDC_WORD_W-1];                         // see RULE2 see RULE3
        end
      end
      default: begin
        next_dout = dout;
      end
    endcase
  end

  // Shift path registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg <= SDC_WORD_RST;
      dout  <= 1'b0;
    end else begin
      shreg <= next_shreg;
      dout  <= next_dout;
    end
  end

  // Word hand-over at frame end
  always_comb begin
    next_word       = word;
    next_word_valid = 1'b0;
    case (state)
      SDC_LATCH: begin
        next_word       = shreg;                                   // see RULE6 see RULE7
        next_word_valid = 1'b1;
      end
      default: begin
        next_word_valid = 1'b0;
      end
    endcase
  end

  // Hand-over registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word       <= SDC_WORD_RST;
      word_valid <= 1'b0;
    end else begin
      word       <= next_word;
      word_valid <= next_word_valid;
    end
  end

  // Mode flag from a chain command
  always_comb begin
    next_chain_en = chain_en;
    case (state)
      SDC_LATCH: begin
        if (is_chain_cmd(shreg)) begin
          next_chain_en = data_bit_zero;                           // see RULE11
        end
      end
      default: begin
        next_chain_en = chain_en;
      end
    endcase
  end

  // Mode register, standalone after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chain_en <= SDC_CHAIN_RST;                                   // see RULE12
    end else begin
      chain_en <= next_chain_en;
    end
  end

  // Pin follows the next mode so enable and flag move together
  always_comb begin
    next_dout_pin = next_chain_en ? next_dout : 1'b0;              // see RULE10
    next_dout_oe  = next_chain_en;                                 // see RULE10
  end

  // Pin registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dout_pin <= 1'b0;
      dout_oe  <= 1'b0;
    end else begin
      dout_pin <= next_dout_pin;
      dout_oe  <= next_dout_oe;
    end
  end

  assign o_serial_data_out    = dout_pin;
  assign o_serial_data_out_oe = dout_oe;
  assign o_chain_enable       = chain_en;
  assign o_word               = word;
  assign o_word_valid         = word_valid;
endmodule // sdc_chain_shifter

// ==== sdc_checker.sv ====
// Purpose: Port checks for the chain shifter
// Assumes: Link pins hold each level 6+ core cycles
// Notes:   Bound to the top module
`timescale 1ns/100ps
module sdc_checker
  import sdc_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_sclk,
  input wire logic                  i_sync_n,
  input wire logic                  i_serial_data_in,
  input wire logic                  o_serial_data_out,
  input wire logic                  o_serial_data_out_oe,
  input wire logic                  o_chain_enable,
  input wire logic [SDC_WORD_W-1:0] o_word,
  input wire logic                  o_word_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  AST_OE_IS_CHAIN: assert property (o_serial_data_out_oe == o_chain_enable)
    else $error("oe differs from chain flag");
  AST_VALID_ONE: assert property (o_word_valid |=> !o_word_valid)
    else $error("valid longer than a cycle");
  AST_WORD_ON_VALID: assert property ($changed(o_word) |-> o_word_valid)
    else $error("word moved without valid");
  AST_MODE_ON_VALID: assert property ($changed(o_chain_enable) |-> o_word_valid)
    else $error("mode moved without valid");
  AST_MODE_CMD: assert property (o_word_valid && o_word[SDC_CMD_MSB:SDC_CMD_LSB] == SDC_CMD_CHAIN
    |-> o_chain_enable == o_word[SDC_CHAIN_BIT]) else $error("mode not taken from word");
  AST_VALID_SYNC_HIGH: assert property (o_word_valid |-> $past(i_sync_n, 4))
    else $error("valid while frame open");
  AST_SYNC_LATCH: assert property ($rose(i_sync_n) |-> ##[3:8] o_word_valid)
    else $error("frame end not latched");
  AST_DOUT_ON_RISE: assert property (o_chain_enable && $past(o_chain_enable, 2)
    && $changed(o_serial_data_out) |-> $past(i_sclk, 2)) else $error("data out moved off rise");
endmodule // sdc_checker
bind sdc_chain_shifter sdc_checker chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
  .i_sync_n(i_sync_n), .i_serial_data_in(i_serial_data_in), .o_word(o_word),
  .o_serial_data_out(o_serial_data_out), .o_serial_data_out_oe(o_serial_data_out_oe),
  .o_chain_enable(o_chain_enable), .o_word_valid(o_word_valid));

// ==== sdc_host_model.sv ====
// Purpose: Host controller sending frames and listening on data out
// Assumes: Link clock idles low between frames
// Notes:   Frames started by task calls from the bench
`timescale 1ns/100ps
module sdc_host_model (
  output logic        o_sclk,
  output logic        o_sync_n,
  output logic        o_data,
  input  wire logic   i_data,
  output logic [47:0] o_rx
);
  initial begin
    o_sclk = 1'b0;
    o_sync_n = 1'b1;
    o_data = 1'b0;
    o_rx = '0;
  end
  // Exact burst of n clocks, MSB first
  task automatic frame(input logic [47:0] d, input int n);
    o_sync_n = 1'b0;
    #125;
    for (int k = n - 1; k >= 0; k--) begin
      o_data = d[k];
      o_sclk = 1'b1;
      #62.5;
      o_sclk = 1'b0;
      o_rx = {o_rx[46:0], i_data};
      #62.5;
    end
    #62.5;
    o_sync_n = 1'b1;
    o_data = ~o_data;
    #250;
  endtask
  // Clocks with the frame closed
  task automatic stray();
    repeat (3) begin
      o_data = ~o_data;
      o_sclk = 1'b1;
      #62.5;
      o_sclk = 1'b0;
      #62.5;
    end
  endtask
endmodule // sdc_host_model

// ==== spi_daisy_chain_shifter_tb.sv ====
// Purpose: Self-checking bench for the chain shifter
// Assumes: Host model drives the link pins
// Notes:   Frames of 24, 28 and 48 clocks
`timescale 1ns/100ps
module spi_daisy_chain_shifter_tb;
  import sdc_pkg::*;
  logic                  i_clk, i_rst_n, sclk, sync_n, ser_in, ser_out, oe, chain, valid;
  logic [SDC_WORD_W-1:0] word;
  logic [47:0]           rx;
  int                    err_count, cmp_count, cyc, nval;
  sdc_chain_shifter dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_sync_n(sync_n),
    .i_serial_data_in(ser_in), .o_serial_data_out(ser_out), .o_serial_data_out_oe(oe),
    .o_chain_enable(chain), .o_word(word), .o_word_valid(valid));
  sdc_host_model host_u (.o_sclk(sclk), .o_sync_n(sync_n), .o_data(ser_in), .i_data(ser_out),
    .o_rx(rx));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (valid === 1'b1) nval <= nval + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [47:0] d, input int n, input logic [23:0] w, input logic c);
    int v;
    v = nval;
    @(posedge i_clk);
    #1;
    host_u.frame(d, n);
    check(word, w);
    check(nval - v, 1);
    check(chain, c);
    check(oe, c);
  endtask
  task automatic t_standalone();
    check(chain, 0);
    run(48'hffffff5a3c96, 48, 24'h5a3c96, 1'b0);
    check(ser_out, 0);
    check(rx[23:0], 24'h000000);
  endtask
  task automatic t_chain();
    run(48'h800001, 24, 24'h800001, 1'b1);
    run(48'h1234560f0f0f, 48, 24'h0f0f0f, 1'b1);
    check(rx, 48'h800001123456);
  endtask
  task automatic t_odd();
    run(48'ha654321, 28, 24'h654321, 1'b1);
  endtask
  task automatic t_stray();
    int v;
    v = nval;
    host_u.stray();
    repeat (10) @(posedge i_clk);
    check(nval - v, 0);
    check(word, 24'h654321);
    run(48'h800000, 24, 24'h800000, 1'b0);
    check(ser_out, 0);
  endtask
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    repeat (4) @(posedge i_clk);
    t_standalone();
    t_chain();
    t_odd();
    t_stray();
    summarize();
  end
endmodule // spi_daisy_chain_shifter_tb
